/* File: rtl/osd_ctl_pkg.sv */
/*
 holds: address map, field positions, reset values and codes of the caption display control block.
 assumes: imported whole by the design modules.
*/
package osd_ctl_pkg;
    localparam logic [15:0] REG_BASE = 16'h87F0;
    localparam logic [15:0] REG_LAST = 16'h87FF;
    localparam logic [15:0] DISPLAY_CONTROL_ADDR = 16'h87F0;
    localparam logic [15:0] TEXT_VERTICAL_POSITION_ADDR = 16'h87F1;
    localparam logic [15:0] TEXT_AREA_BEGIN_ADDR = 16'h87F2;
    localparam logic [15:0] FRINGE_CONTROL_ADDR = 16'h87F3;
    localparam logic [15:0] TEXT_AREA_FINISH_ADDR = 16'h87F4;
    localparam logic [15:0] SCROLL_WINDOW_ADDR = 16'h87F5;
    localparam logic [15:0] SCROLL_ROWS_ADDR = 16'h87F6;
    localparam logic [15:0] BLANKING_POLARITY_ADDR = 16'h87F7;
    localparam logic [15:0] DISPLAY_STATUS_ADDR = 16'h87F8;
    localparam logic [15:0] HSYNC_DELAY_ADDR = 16'h87FC;
    localparam logic [15:0] VSYNC_DELAY_ADDR = 16'h87FD;
    localparam logic [15:0] SCROLL_TOP_LINE_ADDR = 16'h87FE;
    localparam logic [15:0] DISPLAY_CONFIG_ADDR = 16'h87FF;
    // redefinable character ram window
    localparam logic [15:0] RCHAR_BASE = 16'h8800;
    localparam int RCHAR_COUNT = 16;
    localparam int RCHAR_ROWS = 18;
    localparam int RCHAR_WORDS = RCHAR_COUNT * 32;
    localparam int RCHAR_AW = 9;
    localparam logic [15:0] RCHAR_SPAN = 16'h0400;
    localparam logic [7:0] RCHAR_CODE_FIRST = 8'h80;
    localparam logic [7:0] RCHAR_CODE_LAST = 8'h8F;
    localparam logic [7:0] SPECIAL_CODE_LAST = 8'h87;
    localparam logic [7:0] REG_RESET = 8'h00;
    // field positions
    localparam int VSYNC_INV_BIT = 7;
    localparam int HSYNC_INV_BIT = 6;
    localparam int BLANK_POL_BIT = 7;
    localparam int STATUS_BUSY_BIT = 7;
    localparam int STATUS_FIELD_BIT = 6;
    localparam logic [7:0] STATUS_WR_MASK = 8'h3F;
    localparam logic [7:0] HSD_MASK = 8'h7F;
    localparam logic [7:0] SCL_MASK = 8'h1F;
    localparam logic [7:0] POL_MASK = 8'h80;
    localparam logic [7:0] CONFIG_MASK = 8'hF8;
    localparam logic [7:0] DISPCTL_MASK = 8'hFB;
    localparam int BLANKING_DELAY_LSB = 4;
    localparam int PIXEL_ROW_LSB = 1;
    localparam int LINE_13_OFFSET = 1;
    localparam int CR_REGION_BIT = 12;
    localparam logic [1:0] CR_INSIDE = 2'b01;
    localparam logic [1:0] CR_OUTSIDE = 2'b10;
    typedef enum logic [1:0] {
        BLANKING_DELAY_COINCIDENT = 2'b00,
        BLANKING_DELAY_EARLY = 2'b01,
        BLANKING_DELAY_LATE = 2'b10,
        BLANKING_DELAY_OTHER = 2'b11
    } blanking_delay_e;
    typedef enum logic [1:0] {
        ROWS_FROM_FIRST = 2'b00,
        ROWS_AFTER_FRINGE = 2'b01
    } row_mode_e;
endpackage

/* File: rtl/rchar_ram.sv */
/*
 holds: word memory for the redefinable characters, byte writes, registered read port.
 assumes: one clock; write and read ports on the same edge.
*/
`timescale 1ns/10ps
module rchar_ram
    import osd_ctl_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // write side
    input wire logic wr_en,
    input wire logic wr_hi,
    input wire logic [RCHAR_AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read side
    input wire logic [RCHAR_AW-1:0] rd_addr,
    output logic [15:0] rd_data
);
    logic [7:0] lo_mem [RCHAR_WORDS];
    logic [7:0] hi_mem [RCHAR_WORDS];
    logic [15:0] rd_q;

    always_ff @(posedge ref_clk) begin
        if (wr_en && !wr_hi) begin
            lo_mem[wr_addr] <= wr_data;
        end
        if (wr_en && wr_hi) begin
            hi_mem[wr_addr] <= wr_data;
        end
        rd_q <= {hi_mem[rd_addr], lo_mem[rd_addr]};
    end

    assign rd_data = rd_q;
endmodule

/* File: rtl/caption_osd_display_control.sv */
/*
 holds: control registers, redefinable character store, sync conditioning and fast-blanking output
 of the caption display.
 assumes: ref_clk is the line-locked display clock; the controller's external data moves arrive
 as one-cycle strobes on this clock; renderer supplies codes, rows and blanking request.
*/
// Contract
// - one 256-code set, one matrix size shown
// - sixteen redefinable codes 80H to 8FH
// - planes select gives eight special graphics
// - enable bit swaps ram for rom patterns
// - each location holds 16 by 18
// - character ram based at 8800H
// - even byte low, odd byte high
// - 9/10/16/18 rows start at first word
// - 13 rows start one word in
// - sync inputs invert by own bits
// - display logic on line-locked clock
// - syncs synchronised before display use
// - blanking level set by polarity bit
// - blanking shift early, late or none
// - contrast region follows coding bit 12
// - control registers at 87F0h to 87FFh
`timescale 1ns/10ps
module caption_osd_display_control
    import osd_ctl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // external data space
    input wire logic [15:0] xd_addr,
    input wire logic [7:0] xd_wdata,
    input wire logic xd_wr,
    input wire logic xd_rd,
    output logic [7:0] xd_rdata,
    // special function controls
    input wire logic redef_char_enable,
    input wire logic symbol_planes_select,
    input wire logic [1:0] contrast_reduce_ctl,
    // sync pins
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    // renderer side
    input wire logic [7:0] char_code,
    input wire logic [4:0] char_line,
    input wire logic line_13_mode,
    input wire logic [15:0] rom_pattern,
    input wire logic [15:0] coding_word,
    input wire logic in_box,
    input wire logic rgb_active,
    input wire logic display_busy,
    input wire logic field_odd,
    // outputs
    output logic [15:0] pattern_out,
    output logic pattern_from_ram,
    output logic contrast_reduce,
    output logic hsync_sync,
    output logic vsync_sync,
    output logic fast_blanking_out,
    output logic [7:0] display_control,
    output logic [7:0] text_vertical_position,
    output logic [7:0] text_area_begin,
    output logic [7:0] fringe_control,
    output logic [7:0] text_area_finish,
    output logic [7:0] scroll_window,
    output logic [7:0] scroll_rows,
    output logic [7:0] hsync_delay,
    output logic [7:0] vsync_delay,
    output logic [7:0] scroll_top_line,
    output logic [7:0] display_config,
    output logic [5:0] status_ctl
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic in_redef(input logic [7:0] code, input logic planes);
        in_redef = (code >= RCHAR_CODE_FIRST) &&
            (code <= (planes ? SPECIAL_CODE_LAST : RCHAR_CODE_LAST));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0] dc_q, dc_d, tvp_q, tvp_d, tab_q, tab_d, frc_q, frc_d, taf_q, taf_d;
    logic [7:0] sw_q, sw_d, sr_q, sr_d, pol_q, pol_d, st_q, st_d;
    logic [7:0] hsd_q, hsd_d, vsd_q, vsd_d, stl_q, stl_d, cfg_q, cfg_d;
    logic [7:0] rd_q, rd_d;

    always_comb begin
        dc_d = dc_q;
        tvp_d = tvp_q;
        tab_d = tab_q;
        frc_d = frc_q;
        taf_d = taf_q;
        sw_d = sw_q;
        sr_d = sr_q;
        pol_d = pol_q;
        st_d = st_q;
        hsd_d = hsd_q;
        vsd_d = vsd_q;
        stl_d = stl_q;
        cfg_d = cfg_q;
        rd_d = rd_q;
        if (xd_wr) begin
            case (xd_addr)
                DISPLAY_CONTROL_ADDR: dc_d = xd_wdata & DISPCTL_MASK;
                TEXT_VERTICAL_POSITION_ADDR: tvp_d = xd_wdata;
                TEXT_AREA_BEGIN_ADDR: tab_d = xd_wdata;
                FRINGE_CONTROL_ADDR: frc_d = xd_wdata;
                TEXT_AREA_FINISH_ADDR: taf_d = xd_wdata;
                SCROLL_WINDOW_ADDR: sw_d = xd_wdata;
                SCROLL_ROWS_ADDR: sr_d = xd_wdata;
                BLANKING_POLARITY_ADDR: pol_d = xd_wdata & POL_MASK;
                DISPLAY_STATUS_ADDR: st_d = xd_wdata & STATUS_WR_MASK;
                HSYNC_DELAY_ADDR: hsd_d = xd_wdata & HSD_MASK;
                VSYNC_DELAY_ADDR: vsd_d = xd_wdata & HSD_MASK;
                SCROLL_TOP_LINE_ADDR: stl_d = xd_wdata & SCL_MASK;
                DISPLAY_CONFIG_ADDR: cfg_d = xd_wdata & CONFIG_MASK;
                default: ;
            endcase
        end
        if (xd_rd) begin
            case (xd_addr)
                DISPLAY_CONTROL_ADDR: rd_d = dc_q;
                TEXT_VERTICAL_POSITION_ADDR: rd_d = tvp_q;
                TEXT_AREA_BEGIN_ADDR: rd_d = tab_q;
                FRINGE_CONTROL_ADDR: rd_d = frc_q;
                TEXT_AREA_FINISH_ADDR: rd_d = taf_q;
                SCROLL_WINDOW_ADDR: rd_d = sw_q;
                SCROLL_ROWS_ADDR: rd_d = sr_q;
                BLANKING_POLARITY_ADDR: rd_d = pol_q;
                DISPLAY_STATUS_ADDR: begin
                    rd_d = st_q;
                    rd_d[STATUS_BUSY_BIT] = display_busy;
                    rd_d[STATUS_FIELD_BIT] = field_odd;
                end
                HSYNC_DELAY_ADDR: rd_d = hsd_q;
                VSYNC_DELAY_ADDR: rd_d = vsd_q;
                SCROLL_TOP_LINE_ADDR: rd_d = stl_q;
                DISPLAY_CONFIG_ADDR: rd_d = cfg_q;
                default: rd_d = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dc_q <= REG_RESET;
            tvp_q <= REG_RESET;
            tab_q <= REG_RESET;
            frc_q <= REG_RESET;
            taf_q <= REG_RESET;
            sw_q <= REG_RESET;
            sr_q <= REG_RESET;
            pol_q <= REG_RESET;
            st_q <= REG_RESET;
            hsd_q <= REG_RESET;
            vsd_q <= REG_RESET;
            stl_q <= REG_RESET;
            cfg_q <= REG_RESET;
            rd_q <= REG_RESET;
        end else begin
            dc_q <= dc_d;
            tvp_q <= tvp_d;
            tab_q <= tab_d;
            frc_q <= frc_d;
            taf_q <= taf_d;
            sw_q <= sw_d;
            sr_q <= sr_d;
            pol_q <= pol_d;
            st_q <= st_d;
            hsd_q <= hsd_d;
            vsd_q <= vsd_d;
            stl_q <= stl_d;
            cfg_q <= cfg_d;
            rd_q <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // redefinable character store
    logic ram_wr;
    logic [15:0] ram_off;
    logic [RCHAR_AW-1:0] wr_word, rd_word, row_idx;
    logic [15:0] ram_rd;

    assign ram_off = xd_addr - RCHAR_BASE;
    assign ram_wr = xd_wr && (xd_addr >= RCHAR_BASE) && (ram_off < RCHAR_SPAN);
    assign wr_word = ram_off[RCHAR_AW:PIXEL_ROW_LSB];

    assign row_idx = RCHAR_AW'(char_line) + (line_13_mode ? RCHAR_AW'(LINE_13_OFFSET) : RCHAR_AW'(0));
    // 32-word slot per code holds 16x18
    assign rd_word = {char_code[3:0], row_idx[4:0]};

    rchar_ram u_ram (
        .ref_clk(ref_clk),
        .wr_en(ram_wr),
        .wr_hi(ram_off[0]),
        .wr_addr(wr_word),
        .wr_data(xd_wdata),
        .rd_addr(rd_word),
        .rd_data(ram_rd)
    );

    ////////////////////////////////////////////////////////////////////////
    // pattern selection
    logic sel_q, sel_d, cr_q, cr_d, src_q, src_d;
    logic [15:0] rom_q, rom_d, pat_q, pat_d;

    always_comb begin
        // one code space for all matrices
        sel_d = redef_char_enable && in_redef(char_code, symbol_planes_select);
        rom_d = rom_pattern;
        pat_d = sel_q ? ram_rd : rom_q;
        src_d = sel_q;
        cr_d = 1'b0;
        case (contrast_reduce_ctl)
            CR_INSIDE: cr_d = coding_word[CR_REGION_BIT] && in_box;
            CR_OUTSIDE: cr_d = coding_word[CR_REGION_BIT] && !in_box;
            default: cr_d = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sel_q <= 1'b0;
            rom_q <= 16'h0000;
            pat_q <= 16'h0000;
            cr_q <= 1'b0;
            src_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            src_q <= src_d;
            rom_q <= rom_d;
            pat_q <= pat_d;
            cr_q <= cr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sync conditioning
    logic [2:0] hs_q, hs_d, vs_q, vs_d;
    logic hstab_q, hstab_d, vstab_q, vstab_d;

    always_comb begin
        hs_d = {hs_q[1:0], hsync_pin ^ tvp_q[HSYNC_INV_BIT]};
        vs_d = {vs_q[1:0], vsync_pin ^ tvp_q[VSYNC_INV_BIT]};
        hstab_d = (hs_q[1] == hs_q[2]) ? hs_q[2] : hstab_q;
        vstab_d = (vs_q[1] == vs_q[2]) ? vs_q[2] : vstab_q;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hs_q <= 3'b000;
            vs_q <= 3'b000;
            hstab_q <= 1'b0;
            vstab_q <= 1'b0;
        end else begin
            hs_q <= hs_d;
            vs_q <= vs_d;
            hstab_q <= hstab_d;
            vstab_q <= vstab_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fast blanking
    logic a0_q, a1_q, a2_q, fb_q, fb_d;
    logic [1:0] blanking_delay;

    assign blanking_delay = cfg_q[BLANKING_DELAY_LSB+1:BLANKING_DELAY_LSB];

    always_comb begin
        if (cfg_q[BLANKING_DELAY_LSB+2]) begin
            fb_d = a1_q;
        end else begin
            case (blanking_delay)
                BLANKING_DELAY_EARLY: fb_d = a0_q;
                BLANKING_DELAY_LATE: fb_d = a2_q;
                default: fb_d = a1_q;
            endcase
        end
        fb_d = fb_d ^ pol_q[BLANK_POL_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            a0_q <= 1'b0;
            a1_q <= 1'b0;
            a2_q <= 1'b0;
            fb_q <= 1'b0;
        end else begin
            a0_q <= rgb_active;
            a1_q <= a0_q;
            a2_q <= a1_q;
            fb_q <= fb_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign xd_rdata = rd_q;
    assign pattern_out = pat_q;
    assign pattern_from_ram = src_q;
    assign contrast_reduce = cr_q;
    assign hsync_sync = hstab_q;
    assign vsync_sync = vstab_q;
    assign fast_blanking_out = fb_q;
    assign display_control = dc_q;
    assign text_vertical_position = tvp_q;
    assign text_area_begin = tab_q;
    assign fringe_control = frc_q;
    assign text_area_finish = taf_q;
    assign scroll_window = sw_q;
    assign scroll_rows = sr_q;
    assign hsync_delay = hsd_q;
    assign vsync_delay = vsd_q;
    assign scroll_top_line = stl_q;
    assign display_config = cfg_q;
    assign status_ctl = st_q[5:0];
endmodule

/* File: sim/osd_ctl_properties.sv */
/*
 holds: port checks of the caption display control block.
 assumes: bound into the top module; package compiled first.
*/
`timescale 1ns/10ps
module osd_ctl_properties
    import osd_ctl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // data space
    input wire logic [15:0] xd_addr,
    input wire logic [7:0] xd_wdata,
    input wire logic xd_wr,
    input wire logic xd_rd,
    input wire logic [7:0] xd_rdata,
    // pins and renderer
    input wire logic redef_char_enable,
    input wire logic symbol_planes_select,
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    input wire logic [7:0] char_code,
    input wire logic [15:0] rom_pattern,
    input wire logic rgb_active,
    input wire logic display_busy,
    input wire logic field_odd,
    // outputs
    input wire logic [15:0] pattern_out,
    input wire logic pattern_from_ram,
    input wire logic hsync_sync,
    input wire logic vsync_sync,
    input wire logic fast_blanking_out,
    input wire logic [7:0] text_vertical_position,
    input wire logic [7:0] display_config,
    input wire logic [5:0] status_ctl
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] quiet_q, quiet_d;
    logic pol_q, pol_d;
    logic want_ram;
    logic coinc;
    ////////////////////////////////////////////////////////////
    // cycles since last write or reset, tracked polarity
    always_comb begin
        quiet_d = (quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1;
        pol_d = (xd_wr && xd_addr == BLANKING_POLARITY_ADDR) ? xd_wdata[7] : pol_q;
        if (xd_wr || sys_rst) begin
            quiet_d = 4'h0;
        end
        if (sys_rst) begin
            pol_d = 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        quiet_q <= quiet_d;
        pol_q <= pol_d;
    end
    assign want_ram = redef_char_enable && char_code >= RCHAR_CODE_FIRST
        && char_code <= (symbol_planes_select ? SPECIAL_CODE_LAST : RCHAR_CODE_LAST);
    assign coinc = display_config[6:4] != 3'b001 && display_config[6:4] != 3'b010;
    ////////////////////////////////////////////////////////////
    a_reg_write: assert property (
        xd_wr && xd_addr == TEXT_VERTICAL_POSITION_ADDR |=> text_vertical_position == $past(xd_wdata))
        else $error("register write not stored");
    a_config_mask: assert property (
        xd_wr && xd_addr == DISPLAY_CONFIG_ADDR |=> display_config == ($past(xd_wdata) & CONFIG_MASK))
        else $error("configuration write wrong");
    a_status_write: assert property (
        xd_wr && xd_addr == DISPLAY_STATUS_ADDR |=> {2'b00, status_ctl} == ($past(xd_wdata) & STATUS_WR_MASK))
        else $error("status write wrong");
    a_status_read: assert property (
        xd_rd && xd_addr == DISPLAY_STATUS_ADDR
        |=> xd_rdata == {$past(display_busy), $past(field_odd), $past(status_ctl)})
        else $error("status read wrong");
    a_unmapped_zero: assert property (
        xd_rd && xd_addr > DISPLAY_STATUS_ADDR && xd_addr < HSYNC_DELAY_ADDR |=> xd_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !xd_rd |=> $stable(xd_rdata))
        else $error("read data moved without read");
    a_hsync_path: assert property (
        quiet_q > 4'h6 |-> hsync_sync == ($past(hsync_pin, 4) ^ text_vertical_position[HSYNC_INV_BIT]))
        else $error("hsync path wrong");
    a_vsync_path: assert property (
        quiet_q > 4'h6 |-> vsync_sync == ($past(vsync_pin, 4) ^ text_vertical_position[VSYNC_INV_BIT]))
        else $error("vsync path wrong");
    a_blank_coinc: assert property (
        quiet_q > 4'h6 && coinc |-> fast_blanking_out == ($past(rgb_active, 3) ^ pol_q))
        else $error("coincident blanking wrong");
    a_blank_early: assert property (
        quiet_q > 4'h6 && display_config[6:4] == 3'b001 |-> fast_blanking_out == ($past(rgb_active, 2) ^ pol_q))
        else $error("early blanking wrong");
    a_blank_late: assert property (
        quiet_q > 4'h6 && display_config[6:4] == 3'b010 |-> fast_blanking_out == ($past(rgb_active, 4) ^ pol_q))
        else $error("late blanking wrong");
    a_pattern_source: assert property (
        quiet_q > 4'h6 |-> pattern_from_ram == $past(want_ram, 2))
        else $error("pattern source wrong");
    a_rom_pass: assert property (
        quiet_q > 4'h6 && !pattern_from_ram |-> pattern_out == $past(rom_pattern, 2))
        else $error("rom pattern not passed");
    c_early: cover property (display_config[6:4] == 3'b001 && $rose(fast_blanking_out));
    c_ram: cover property (pattern_from_ram);
    c_status: cover property (xd_rd && xd_addr == DISPLAY_STATUS_ADDR);
endmodule
bind caption_osd_display_control osd_ctl_properties i_osd_ctl_properties (.*);

/* File: sim/xdata_master.sv */
/*
 holds: controller model issuing external data moves.
 assumes: one-cycle strobes, inputs changed at falling edge.
*/
`timescale 1ns/10ps
module xdata_master
    import osd_ctl_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // data space
    output logic [15:0] xd_addr,
    output logic [7:0] xd_wdata,
    output logic xd_wr,
    output logic xd_rd,
    input wire logic [7:0] xd_rdata
);
    initial begin
        xd_addr = 16'h0000;
        xd_wdata = 8'h00;
        xd_wr = 1'b0;
        xd_rd = 1'b0;
    end
    // released lines show the inverse
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        xd_addr = a;
        xd_wdata = v;
        xd_wr = 1'b1;
        @(negedge ref_clk);
        xd_wr = 1'b0;
        xd_addr = ~a;
        xd_wdata = ~v;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge ref_clk);
        xd_addr = a;
        xd_rd = 1'b1;
        @(negedge ref_clk);
        xd_rd = 1'b0;
        xd_addr = ~a;
        v = xd_rdata;
    endtask
    // low byte even, high byte odd
    task automatic wr_row(input logic [3:0] slot, input logic [4:0] row, input logic [15:0] w);
        wr(RCHAR_BASE + {6'h00, slot, row, 1'b0}, w[7:0]);
        wr(RCHAR_BASE + {6'h00, slot, row, 1'b1}, w[15:8]);
    endtask
endmodule

/* File: sim/caption_osd_display_control_test.sv */
/*
 holds: directed test of the caption display control block.
 assumes: controller model drives the data space; checker bound.
*/
`timescale 1ns/10ps
module caption_osd_display_control_test
    import osd_ctl_pkg::*;
;
    logic ref_clk, sys_rst, xd_wr, xd_rd, redef_char_enable, symbol_planes_select, hsync_pin, vsync_pin;
    logic line_13_mode, rgb_active, display_busy, field_odd, pattern_from_ram, hsync_sync, vsync_sync;
    logic fast_blanking_out;
    logic [15:0] xd_addr, rom_pattern, pattern_out, exp;
    logic [7:0] xd_wdata, xd_rdata, char_code;
    logic [4:0] char_line;
    logic [15:0] coding_word;
    logic [1:0] contrast_reduce_ctl;
    logic [5:0] status_ctl;
    logic [7:0] mir [12];
    logic in_box, contrast_reduce;
    int mismatches, n_tests;
    logic [7:0] am [12] = '{8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF7, 8'hFC, 8'hFD, 8'hFE, 8'hFF};
    logic [7:0] mk [12] = '{DISPCTL_MASK, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, POL_MASK, HSD_MASK,
        HSD_MASK, SCL_MASK, CONFIG_MASK};
    // code, line, 13-line, planes, enable, expected row
    logic [31:0] pt [8] = '{{8'h85, 5'd0, 3'b001, 16'h1234}, {8'h85, 5'd0, 3'b101, 16'hABCD},
        {8'h80, 5'd17, 3'b001, 16'h8001}, {8'h8F, 5'd0, 3'b001, 16'h5A5A}, {8'h8A, 5'd0, 3'b011, 16'hC3C3},
        {8'h8A, 5'd0, 3'b001, 16'h0F0F}, {8'h85, 5'd0, 3'b000, 16'hC3C3}, {8'h90, 5'd0, 3'b001, 16'hC3C3}};

    caption_osd_display_control i_caption_osd_display_control (
        .ref_clk, .sys_rst, .xd_addr, .xd_wdata, .xd_wr, .xd_rd, .xd_rdata, .redef_char_enable,
        .symbol_planes_select, .contrast_reduce_ctl, .hsync_pin, .vsync_pin, .char_code, .char_line,
        .line_13_mode, .rom_pattern, .coding_word, .in_box, .rgb_active, .display_busy,
        .field_odd, .pattern_out, .pattern_from_ram, .contrast_reduce, .hsync_sync, .vsync_sync,
        .fast_blanking_out, .display_control(mir[0]), .text_vertical_position(mir[1]), .text_area_begin(mir[2]),
        .fringe_control(mir[3]), .text_area_finish(mir[4]), .scroll_window(mir[5]), .scroll_rows(mir[6]),
        .hsync_delay(mir[8]), .vsync_delay(mir[9]), .scroll_top_line(mir[10]), .display_config(mir[11]),
        .status_ctl
    );
    xdata_master i_xdata_master (.ref_clk, .xd_addr, .xd_wdata, .xd_wr, .xd_rd, .xd_rdata);
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk_out(input logic [15:0] got, input logic [15:0] want);
        n_tests++;
        if (got !== want) begin
            mismatches++;
            $display("BAD %0t output %h want %h", $time, got, want);
        end
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] want);
        logic [7:0] v;
        i_xdata_master.rd(a, v);
        n_tests++;
        if (v !== want) begin
            mismatches++;
            $display("BAD %0t read %h got %h want %h", $time, a, v, want);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end
    initial begin
        sys_rst = 1'b1;
        {redef_char_enable, symbol_planes_select, hsync_pin, vsync_pin, line_13_mode} = 5'b00000;
        {rgb_active, display_busy, field_odd, char_code, char_line} = 16'h0000;
        rom_pattern = 16'hC3C3;
        {contrast_reduce_ctl, in_box, coding_word} = 19'h00000;
        ticks(6);
        sys_rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            rd_chk(REG_BASE + 16'(i), 8'h00);
        end
        for (int i = 0; i < 12; i++) begin
            i_xdata_master.wr({8'h87, am[i]}, 8'hFF);
            rd_chk({8'h87, am[i]}, mk[i]);
            if (i != 7) begin
                chk_out(16'(mir[i]), 16'(mk[i]));
            end
            i_xdata_master.wr({8'h87, am[i]}, 8'h00);
        end
        i_xdata_master.wr(16'h87F9, 8'hFF);
        rd_chk(16'h87F9, 8'h00);
        rd_chk(16'h87EF, 8'h00);
        i_xdata_master.wr(DISPLAY_STATUS_ADDR, 8'hFF);
        chk_out(16'(status_ctl), 16'h003F);
        display_busy = 1'b1;
        rd_chk(DISPLAY_STATUS_ADDR, 8'hBF);
        display_busy = 1'b0;
        field_odd = 1'b1;
        rd_chk(DISPLAY_STATUS_ADDR, 8'h7F);
        rgb_active = 1'b1;
        ticks(8);
        chk_out(16'(fast_blanking_out), 16'h0001);
        i_xdata_master.wr(BLANKING_POLARITY_ADDR, 8'h80);
        ticks(8);
        chk_out(16'(fast_blanking_out), 16'h0000);
        i_xdata_master.wr(BLANKING_POLARITY_ADDR, 8'h00);
        for (int c = 0; c < 8; c++) begin
            rgb_active = 1'b0;
            i_xdata_master.wr(DISPLAY_CONFIG_ADDR, {1'b0, 3'(c), 4'h0});
            ticks(8);
            rgb_active = 1'b1;
            ticks(2);
            chk_out(16'(fast_blanking_out), 16'(c == 1));
            ticks(1);
            chk_out(16'(fast_blanking_out), 16'(c != 2));
        end
        for (int inv = 0; inv < 2; inv++) begin
            i_xdata_master.wr(TEXT_VERTICAL_POSITION_ADDR, {1'(inv), 1'(inv), 6'h00});
            {hsync_pin, vsync_pin} = 2'b10;
            ticks(8);
            {hsync_pin, vsync_pin} = 2'b01;
            ticks(3);
            chk_out({14'h0, hsync_sync, vsync_sync}, {14'h0, !1'(inv), 1'(inv)});
            ticks(1);
            chk_out({14'h0, hsync_sync, vsync_sync}, {14'h0, 1'(inv), !1'(inv)});
        end
        i_xdata_master.wr_row(4'h5, 5'd0, 16'h1234);
        i_xdata_master.wr_row(4'h5, 5'd1, 16'hABCD);
        i_xdata_master.wr_row(4'h0, 5'd17, 16'h8001);
        i_xdata_master.wr_row(4'hF, 5'd0, 16'h5A5A);
        i_xdata_master.wr_row(4'hA, 5'd0, 16'h0F0F);
        for (int i = 0; i < 8; i++) begin
            {char_code, char_line, line_13_mode, symbol_planes_select, redef_char_enable, exp} = pt[i];
            ticks(2);
            chk_out(pattern_out, exp);
            chk_out(16'(pattern_from_ram), 16'(exp != 16'hC3C3));
        end
        for (int k = 0; k < 16; k++) begin
            contrast_reduce_ctl = 2'(k >> 2);
            coding_word = k[1] ? 16'hFFFF : 16'hEFFF;
            in_box = k[0];
            ticks(1);
            chk_out(16'(contrast_reduce), 16'(k == 7 || k == 10));
        end
        finish_test();
    end
endmodule
